// File: mii_tx_4b5b_encoder.sv
// Transmit front end: samples MII or RMII transmit data and emits 5-bit code-groups.
`timescale 1ns/100ps
`include "mte_consts.svh"
// Function
// [RL1] MII: take a 4-bit nibble with TX_EN on each rising link clock edge.
// [RL2] RMII: take a 2-bit dibit with TX_EN on each rising reference clock edge.
// [RL3] While encoding, every received nibble is converted to a 5-bit code-group before output.
// [RL4] Data uses only the 16 data code-groups, never control or invalid ones.
// [RL5] Encoding is skipped when the encode control bit is clear, applied when set.
// [RL6] In bypass the symbol is TX_ER above the four TXD bits.
// [RL7] Bypass only works in MII mode; RMII always encodes.
// [RL8] On rising TX_EN emit J then K in place of the first preamble nibbles.
// [RL9] On falling TX_EN emit T then R, then IDLE; H while TX_ER in frame.
module mii_tx_4b5b_encoder (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic link_clk,
   input wire logic [3:0] txd,
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic rmii_sel,
   input wire logic encode_en,
   output logic [4:0] sym_out,
   output logic sym_vld
);
   logic lk_s1_ff, lk_s2_ff, lk_s3_ff;
   logic [5:0] pin_s1_ff, pin_s2_ff;
   logic mode_s1_ff, mode_s2_ff;
   logic phase_ff, nxt_phase;
   logic [1:0] lo_ff;
   logic [4:0] sym_ff, nxt_sym;
   logic sym_vld_ff;
   mte_pkg::mte_state_t state_ff, nxt_state;

   // Link clock, MAC data and mode strap all cross in through two flip-flops; the
   // data stages match the clock stages so the sampled data lines up with the edge.
   // Clearing them in reset means a link clock that is already high shows one false rise.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         lk_s1_ff <= 1'h0;
         lk_s2_ff <= 1'h0;
         lk_s3_ff <= 1'h0;
         pin_s1_ff <= 6'h00;
         pin_s2_ff <= 6'h00;
         mode_s1_ff <= 1'h0;
         mode_s2_ff <= 1'h0;
      end else if (clk_en) begin
         lk_s1_ff <= link_clk;
         lk_s2_ff <= lk_s1_ff;
         lk_s3_ff <= lk_s2_ff;
         pin_s1_ff <= {tx_er, tx_en, txd};
         pin_s2_ff <= pin_s1_ff;
         mode_s1_ff <= rmii_sel;
         mode_s2_ff <= mode_s1_ff;
      end
   end

   // Decoding of edges, data lanes and the bypass condition. A rise is seen two system
   // clocks after the pin edge, and a link clock above half the system rate is lost.
   wire link_rise = lk_s2_ff & ~lk_s3_ff; // see [RL1] see [RL2]
   wire rmii_mode = mode_s2_ff;
   wire s_er = pin_s2_ff[`MTE_PIN_ER];
   wire s_en = pin_s2_ff[`MTE_PIN_EN];
   wire [3:0] s_txd = pin_s2_ff[`MTE_NIB_W-1:0];
   // In RMII a symbol leaves on the high dibit of a frame, or on any edge between frames.
   wire nib_evt = link_rise & (~rmii_mode | phase_ff | ~s_en); // see [RL2]
   wire [3:0] cur_nib = rmii_mode ? {s_txd[`MTE_DIBIT_W-1:0], lo_ff} : s_txd; // see [RL2]
   wire bypass = ~rmii_mode & ~encode_en; // see [RL5] see [RL7]
   wire [4:0] bypass_sym = {s_er, s_txd}; // see [RL6]
   wire [4:0] data_sym;

   mte_nibble_map u_map (
      .nibble(cur_nib),
      .code_grp(data_sym)
   );

   // RMII dibit pairing: the first dibit is the low half. While tx_en is low the phase is
   // held low, so a frame's first dibit lands in the low half whatever the idle gap was;
   // the price is that idle symbols come at the dibit rate rather than the nibble rate.
   always_comb begin
      nxt_phase = phase_ff;
      if (link_rise) begin
         nxt_phase = (rmii_mode & s_en) ? ~phase_ff : 1'h0; // see [RL2]
      end
   end

   // Symbol sequencer: delimiters around the frame, IDLE between frames. A dropped tx_en
   // wins over tx_er, so a frame that ends in error still closes with T then R, and the
   // far end learns of the error from the H symbols that came before.
   always_comb begin
      nxt_state = state_ff;
      nxt_sym = sym_ff;
      if (nib_evt) begin
         if (bypass) begin
            nxt_sym = bypass_sym; // see [RL6]
            nxt_state = mte_pkg::MTE_ST_IDLE;
         end else begin
            case (state_ff)
               mte_pkg::MTE_ST_IDLE: begin
                  nxt_sym = s_en ? `MTE_CG_J : `MTE_CG_IDLE; // see [RL8] see [RL9]
                  nxt_state = s_en ? mte_pkg::MTE_ST_SSD_K : mte_pkg::MTE_ST_IDLE;
               end
               mte_pkg::MTE_ST_SSD_K: begin
                  nxt_sym = `MTE_CG_K; // see [RL8]
                  nxt_state = mte_pkg::MTE_ST_DATA;
               end
               mte_pkg::MTE_ST_DATA: begin
                  if (!s_en) begin
                     nxt_sym = `MTE_CG_T; // see [RL9]
                     nxt_state = mte_pkg::MTE_ST_ESD_R;
                  end else if (s_er) begin
                     nxt_sym = `MTE_CG_H; // see [RL9]
                  end else begin
                     nxt_sym = data_sym; // see [RL3] see [RL4]
                  end
               end
               mte_pkg::MTE_ST_ESD_R: begin
                  nxt_sym = `MTE_CG_R; // see [RL9]
                  nxt_state = mte_pkg::MTE_ST_IDLE;
               end
               default: begin
                  nxt_sym = `MTE_CG_IDLE;
                  nxt_state = mte_pkg::MTE_ST_IDLE;
               end
            endcase
         end
      end
   end

   // Output and sequencer registers; the valid strobe lasts one cycle per symbol. With the
   // enable low every register holds, so a stalled block resumes where it stopped.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         phase_ff <= 1'h0;
         lo_ff <= 2'h0;
         sym_ff <= `MTE_SYM_RST;
         sym_vld_ff <= 1'h0;
         state_ff <= mte_pkg::MTE_ST_IDLE;
      end else if (clk_en) begin
         phase_ff <= nxt_phase;
         if (link_rise & ~phase_ff) begin
            lo_ff <= s_txd[`MTE_DIBIT_W-1:0];
         end
         sym_ff <= nxt_sym;
         sym_vld_ff <= nib_evt;
         state_ff <= nxt_state;
      end
   end

   assign sym_out = sym_ff;
   assign sym_vld = sym_vld_ff;

   // Checks on the symbol stream. Each one asks for the enable in its antecedent, since a
   // stalled sequencer holds whatever it had and no symbol can then be due.
   // Longest wait from T to R, in system clocks; covers two periods of the slowest link clock.
   localparam int link_wait_c = `MTE_LINK_WAIT;
   mii_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL1]
      clk_en && link_rise && !rmii_mode |=> sym_vld_ff)
      else $error("MII edge did not produce a symbol.");
   rmii_pairing_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL2]
      clk_en && link_rise && rmii_mode && !phase_ff && s_en |=> !sym_vld_ff)
      else $error("RMII first dibit produced a symbol.");

   // A gap in tx_en must bring the pairing back to the low dibit.
   rmii_realign_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL2]
      clk_en && link_rise && rmii_mode && !s_en |=> !phase_ff)
      else $error("RMII pairing did not restart.");
   data_encode_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL3]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_DATA && s_en && !s_er
      |=> sym_ff == $past(data_sym))
      else $error("Data nibble not encoded.");
   data_codes_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL4]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_DATA && s_en && !s_er
      |=> !(sym_ff inside {`MTE_CG_IDLE, `MTE_CG_J, `MTE_CG_K, `MTE_CG_T, `MTE_CG_R,
      `MTE_CG_H}))
      else $error("Data carried a control code-group.");
   encode_on_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL5]
      clk_en && nib_evt && encode_en && state_ff == mte_pkg::MTE_ST_IDLE && !s_en
      |=> sym_ff == `MTE_CG_IDLE)
      else $error("Encoding enabled but IDLE not sent.");
   bypass_sym_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL6]
      clk_en && nib_evt && !rmii_mode && !encode_en |=> sym_ff == $past({s_er, s_txd}))
      else $error("Bypass symbol is not TX_ER and TXD.");
   rmii_no_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL7]
      clk_en && nib_evt && rmii_mode && state_ff == mte_pkg::MTE_ST_IDLE && s_en
      |=> sym_ff == `MTE_CG_J)
      else $error("RMII mode did not encode.");
   ssd_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL8]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_IDLE && s_en
      |=> sym_ff == `MTE_CG_J && state_ff == mte_pkg::MTE_ST_SSD_K)
      else $error("Start delimiter J missing.");
   esd_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL9]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_DATA && !s_en
      |=> sym_ff == `MTE_CG_T ##[1:link_wait_c] (sym_vld_ff && sym_ff == `MTE_CG_R))
      else $error("End delimiter T then R missing.");

   // The second half of the start delimiter, and the move into the data state.
   ssd_k_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL8]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_SSD_K
      |=> sym_ff == `MTE_CG_K && state_ff == mte_pkg::MTE_ST_DATA)
      else $error("Start delimiter K missing.");

   // An errored nibble inside a frame goes out as the error symbol.
   err_sym_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL9]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_DATA && s_en && s_er
      |=> sym_ff == `MTE_CG_H)
      else $error("Error symbol H missing.");

   // The second half of the end delimiter, and the return to idle.
   esd_r_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL9]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_ESD_R
      |=> sym_ff == `MTE_CG_R && state_ff == mte_pkg::MTE_ST_IDLE)
      else $error("End delimiter R missing.");

   // Between frames only IDLE goes out while encoding, in either interface mode.
   idle_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL9]
      clk_en && nib_evt && !bypass && state_ff == mte_pkg::MTE_ST_IDLE && !s_en
      |=> sym_ff == `MTE_CG_IDLE)
      else $error("IDLE not sent between frames.");

   // Bypass keeps the sequencer parked, so no delimiter leaks out when encoding resumes.
   bypass_state_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL5]
      clk_en && nib_evt && bypass |=> state_ff == mte_pkg::MTE_ST_IDLE)
      else $error("Sequencer left idle in bypass.");

   // The valid strobe marks each symbol once and never stretches while the enable is high.
   vld_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RL1]
      clk_en && sym_vld_ff |=> !sym_vld_ff)
      else $error("Symbol strobe longer than one cycle.");
endmodule : mii_tx_4b5b_encoder

// File: mte_consts.svh
// Constant definitions for the transmit nibble to code-group encoder.
`ifndef MTE_CONSTS_SVH
`define MTE_CONSTS_SVH
`define MTE_CG_0 5'h1E
`define MTE_CG_1 5'h09
`define MTE_CG_2 5'h14
`define MTE_CG_3 5'h15
`define MTE_CG_4 5'h0A
`define MTE_CG_5 5'h0B
`define MTE_CG_6 5'h0E
`define MTE_CG_7 5'h0F
`define MTE_CG_8 5'h12
`define MTE_CG_9 5'h13
`define MTE_CG_A 5'h16
`define MTE_CG_B 5'h17
`define MTE_CG_C 5'h1A
`define MTE_CG_D 5'h1B
`define MTE_CG_E 5'h1C
`define MTE_CG_F 5'h1D
`define MTE_CG_IDLE 5'h1F
`define MTE_CG_J 5'h18
`define MTE_CG_K 5'h11
`define MTE_CG_T 5'h0D
`define MTE_CG_R 5'h07
`define MTE_CG_H 5'h04
`define MTE_SYM_RST 5'h1F
`define MTE_NIB_W 4
`define MTE_SYM_W 5
`define MTE_DIBIT_W 2
`define MTE_PIN_ER 5
`define MTE_PIN_EN 4
`define MTE_LINK_WAIT 40
`endif

// File: mte_mac_model.sv
// Behavioural transmit MAC that drives the link clock and the transmit pins.
`timescale 1ns/100ps
module mte_mac_model (
   output logic link_clk,
   output logic [3:0] txd,
   output logic tx_en,
   output logic tx_er
);
   // Start idle; the clock runs free between frames as a transmit clock does.
   initial begin
      txd = 4'h0;
      tx_en = 1'b0;
      tx_er = 1'b0;
   end
   always begin
      link_clk = 1'b0;
      #200;
      link_clk = 1'b1;
      #200;
   end

   // Pins change at the falling edge, so they are settled at the rising edge that takes them.
   task put(input logic [3:0] d, input logic en, input logic er);
      @(negedge link_clk);
      txd = d;
      tx_en = en;
      tx_er = er;
   endtask : put

   // Between frames the data lines are not held, so they change on every clock.
   task idle(input int n);
      for (int i = 0; i < n; i++) begin
         put(~txd, 1'b0, 1'b0);
      end
   endtask : idle
endmodule : mte_mac_model

// File: mte_nibble_map.sv
// Combinational lookup from a data nibble to its 5-bit data code-group.
`timescale 1ns/100ps
`include "mte_consts.svh"
module mte_nibble_map (
   input wire logic [3:0] nibble,
   output logic [4:0] code_grp
);
   // Only the sixteen data code-groups appear here, so control codes can never carry data.
   always_comb begin
      case (nibble)
         4'h0: code_grp = `MTE_CG_0;
         4'h1: code_grp = `MTE_CG_1;
         4'h2: code_grp = `MTE_CG_2;
         4'h3: code_grp = `MTE_CG_3;
         4'h4: code_grp = `MTE_CG_4;
         4'h5: code_grp = `MTE_CG_5;
         4'h6: code_grp = `MTE_CG_6;
         4'h7: code_grp = `MTE_CG_7;
         4'h8: code_grp = `MTE_CG_8;
         4'h9: code_grp = `MTE_CG_9;
         4'hA: code_grp = `MTE_CG_A;
         4'hB: code_grp = `MTE_CG_B;
         4'hC: code_grp = `MTE_CG_C;
         4'hD: code_grp = `MTE_CG_D;
         4'hE: code_grp = `MTE_CG_E;
         default: code_grp = `MTE_CG_F;
      endcase
   end
endmodule : mte_nibble_map

// File: mte_pkg.sv
// Types shared by the transmit encoder files.
package mte_pkg;
   typedef enum logic [1:0] {
      MTE_ST_IDLE,
      MTE_ST_SSD_K,
      MTE_ST_DATA,
      MTE_ST_ESD_R
   } mte_state_t;
endpackage : mte_pkg

// File: tb_top.sv
// Self-checking bench for the transmit nibble to code-group encoder.
`timescale 1ns/100ps
module tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic rmii_sel = 1'b0;
   logic encode_en = 1'b1;
   logic link_clk;
   logic [3:0] txd;
   logic tx_en;
   logic tx_er;
   logic [4:0] sym_out;
   logic sym_vld;
   logic [4:0] syms[$];
   logic [4:0] cg_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                               5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;

   always #25 sys_clk = ~sys_clk;

   mte_mac_model i_mte_mac_model (.link_clk(link_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
   mii_tx_4b5b_encoder i_mii_tx_4b5b_encoder (.sys_clk(sys_clk), .rst_b(rst_b),
      .clk_en(clk_en), .link_clk(link_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
      .rmii_sel(rmii_sel), .encode_en(encode_en), .sym_out(sym_out), .sym_vld(sym_vld));

   // Keep every new symbol, taken at the falling edge where the registered outputs have
   // settled; a hang is cut short well above the few hundred cycles needed.
   always @(negedge sys_clk) begin
      if (sym_vld === 1'b1) syms.push_back(sym_out);
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task chk(input logic [4:0] seen, input logic [4:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Idle symbols come first, so the stream is aligned on the first expected symbol.
   task judge(input logic [4:0] exp[$], input string name);
      int s;
      s = 0;
      while (s < syms.size() && syms[s] !== exp[0]) s++;
      for (int k = 0; k < exp.size(); k++) chk(syms[s + k], exp[k]);
      $display("test %s done", name);
   endtask : judge

   // Mode inputs change a little after the edge, then the link settles before capture.
   task set_mode(input logic r, input logic e);
      @(posedge sys_clk);
      #5;
      rmii_sel = r;
      encode_en = e;
      i_mte_mac_model.idle(4);
      syms.delete();
   endtask : set_mode

   task t_mii_frame;
      logic [4:0] exp[$];
      set_mode(1'b0, 1'b1);
      exp = {5'h18, 5'h11};
      i_mte_mac_model.put(4'h5, 1'b1, 1'b0);
      i_mte_mac_model.put(4'h5, 1'b1, 1'b0);
      for (int n = 0; n < 16; n++) begin
         i_mte_mac_model.put(n[3:0], 1'b1, 1'b0);
         exp.push_back(cg_tab[n]);
      end
      i_mte_mac_model.put(4'h6, 1'b1, 1'b1);
      exp = {exp, 5'h04, 5'h0D, 5'h07, 5'h1F, 5'h1F};
      i_mte_mac_model.idle(6);
      judge(exp, "mii_frame");
   endtask : t_mii_frame

   task t_bypass;
      set_mode(1'b0, 1'b0);
      i_mte_mac_model.put(4'hA, 1'b1, 1'b1);
      i_mte_mac_model.put(4'h5, 1'b1, 1'b0);
      i_mte_mac_model.put(4'hF, 1'b1, 1'b1);
      i_mte_mac_model.put(4'h0, 1'b1, 1'b0);
      i_mte_mac_model.idle(4);
      judge('{5'h1A, 5'h05, 5'h1F, 5'h00}, "bypass");
   endtask : t_bypass

   // The encode bit is left clear here: the reduced interface must still encode.
   task t_rmii;
      set_mode(1'b1, 1'b0);
      repeat (4) i_mte_mac_model.put(4'h5, 1'b1, 1'b0);
      i_mte_mac_model.put(4'hE, 1'b1, 1'b0);
      i_mte_mac_model.put(4'h2, 1'b1, 1'b0);
      i_mte_mac_model.put(4'h7, 1'b1, 1'b0);
      i_mte_mac_model.put(4'hC, 1'b1, 1'b0);
      i_mte_mac_model.idle(10);
      judge('{5'h18, 5'h11, 5'h16, 5'h15, 5'h0D, 5'h07, 5'h1F}, "rmii");
   endtask : t_rmii

   // With the enable low nothing may move, though link edges keep arriving.
   task t_freeze;
      logic [4:0] held;
      int n;
      while (sym_vld !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      #5;
      clk_en = 1'b0;
      held = sym_out;
      n = syms.size();
      repeat (40) @(posedge sys_clk);
      #5;
      chk(held, 5'h1F);
      chk(sym_out, held);
      chk({4'h0, syms.size() == n}, 5'h01);
      clk_en = 1'b1;
      $display("test freeze done");
   endtask : t_freeze

   // A second reset in mid-run must bring the outputs back to their idle values.
   task t_reset_mid;
      @(posedge sys_clk);
      #5;
      rst_b = 1'b0;
      repeat (5) @(posedge sys_clk);
      #5;
      rst_b = 1'b1;
      chk(sym_out, 5'h1F);
      chk({4'h0, sym_vld}, 5'h00);
      $display("test mid reset done");
   endtask : t_reset_mid

   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5) @(posedge sys_clk);
      #5;
      rst_b = 1'b1;
      chk(sym_out, 5'h1F);
      chk({4'h0, sym_vld}, 5'h00);
      $display("test reset done");
      t_mii_frame();
      t_bypass();
      t_rmii();
      t_freeze();
      t_reset_mid();
      tally_and_finish();
   end
endmodule : tb_top
